// ==== adcc_pkg.sv ====
// Package for the converter control block: offsets, fields, timing
package adcc_pkg;
   // Register indices on the plain port (byte address equals index)
   localparam logic [2:0] ADDR_CHREF   = 3'h0; // channel_reference_register
   localparam logic [2:0] ADDR_CTRL    = 3'h1; // converter_control_status_register
   localparam logic [2:0] ADDR_TRIG    = 3'h2; // special_function_io_register
   localparam logic [2:0] ADDR_LOW     = 3'h3; // result_low_byte
   localparam logic [2:0] ADDR_HIGH    = 3'h4; // result_high_byte
   localparam logic [2:0] ADDR_FLAGCLR = 3'h5; // write ones to clear trigger flags
   // channel_reference_register fields
   localparam int CH_LSB     = 0;
   localparam int CH_W       = 5;
   localparam int LADJ_BIT   = 5;
   localparam int REF_LSB    = 6;
   // converter_control_status_register fields
   localparam int EN_BIT     = 7;
   localparam int SC_BIT     = 6;
   localparam int ATE_BIT    = 5;
   localparam int CCF_BIT    = 4;
   localparam int PS_LSB     = 0;
   localparam int PS_W       = 3;
   // special_function_io_register fields
   localparam int TS_LSB     = 5;
   localparam int TS_W       = 3;
   // Trigger source code meaning the converter's own completion flag
   localparam logic [2:0] TS_FREE = 3'h0;
   // Reference selection codes
   localparam logic [1:0] REF_PIN    = 2'h0;
   localparam logic [1:0] REF_SUPPLY = 2'h1;
   localparam logic [1:0] REF_INT256 = 2'h3;
   // Channel codes below this are single-ended; at and above, differential
   localparam logic [4:0] CH_DIFF_FIRST = 5'h08;
   // Gain codes driven to the gain stage
   localparam logic [1:0] GAIN_1X   = 2'h0;
   localparam logic [1:0] GAIN_10X  = 2'h1;
   localparam logic [1:0] GAIN_200X = 2'h2;
   localparam logic [1:0] GAIN_BYP  = 2'h3;
   // Conversion lengths in converter clock cycles
   localparam logic [4:0] CONV_NORMAL = 5'd13;
   localparam logic [4:0] CONV_FIRST  = 5'd25;
   localparam int RES_W = 10;
   localparam logic [7:0] ZERO8 = 8'h00;
   typedef enum logic [1:0] {
      ADCC_IDLE = 2'b00,
      ADCC_CONV = 2'b01,
      ADCC_DONE = 2'b10
   } adcc_state_t;
   // Gain and bypass decode for a channel code
   function automatic logic [1:0] gain_of(input logic [4:0] ch);
      logic [1:0] g;
      g = GAIN_BYP;
      if (ch >= CH_DIFF_FIRST)
      begin
         case (ch[1:0])
            2'h0:    g = GAIN_1X;
            2'h1:    g = GAIN_10X;
            2'h2:    g = GAIN_200X;
            default: g = GAIN_1X;
         endcase
      end
      return g;
   endfunction
endpackage

// ==== adcc_sar.sv ====
// Successive approximation register: one bit per step, MSB first
`timescale 1ns/1ps
`default_nettype none
module adcc_sar
(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        clear,
   input  wire logic        step,
   input  wire logic        comp_high,
   output logic [9:0]       trial,
   output logic [9:0]       code,
   output logic             full
);
   logic [9:0] mask;
   // Trial keeps decided bits plus the bit under test
   assign trial = code | mask;
   assign full  = (mask == 10'h000);
   // Keep bit if comparator says input above trial, then move on
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         code <= 10'h000;
         mask <= 10'h200;
      end
      else if (clear)
      begin
         code <= 10'h000;
         mask <= 10'h200;
      end
      else if (step && !full)
      begin
         if (comp_high)
            code <= code | mask;
         mask <= mask >> 1;
      end
   end
endmodule
`default_nettype wire

// ==== adcc_top.sv ====
// Converter control: registers, prescaler, sequencing and result lock
// Function
// - Produce 10-bit successive approximation code, zero is ground.
// - Software picks reference: reference pin, analog supply or internal 2.56V.
// - channel_gain_select picks single-ended pin, ground, bandgap or pin pair.
// - Gain-equipped pairs offer 1x, 10x and 200x in the channel code.
// - Single-ended selection bypasses the gain amplifier.
// - New reference or channel not applied until converter_enable set.
// - Result right-justified by default, left-justified with left_adjust.
// - Low byte read blocks updates; results finishing before high read lost.
// - Reading high byte re-enables result updates.
// - Every completion raises the completion flag, even when discarded.
// - Writing start_conversion starts one; bit stays high until done.
// - Channel change mid-conversion applies only in the last conversion cycle.
// - auto_trigger_enable starts conversions from the selected trigger source.
// - Trigger rising edge resets prescaler and starts conversion.
// - Only edges start; edges during conversion ignored.
// - Trigger flag must be cleared before it can trigger again.
// - Completion flag as trigger runs free regardless of flag clearing.
// - Software start still works with auto trigger; bit reads one while busy.
// - Normal conversion 13 converter clocks, first after enable 25.
// - Prescaler runs while enabled, held in reset while disabled.
// - At completion write result, set flag, clear start in single mode.
// - Selections track until start, hold, resume in last cycle.
`timescale 1ns/1ps
`default_nettype none
module adcc_top
(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic [2:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [7:0]       reg_rdata,
   input  wire logic [7:0]  trig_flag_set,
   input  wire logic        comp_high,
   output logic [9:0]       dac_code,
   output logic [4:0]       mux_select,
   output logic [1:0]       gain_select,
   output logic             gain_bypass,
   output logic [1:0]       ref_select,
   output logic             analog_enable,
   output logic             sample_hold
);
   logic [7:0] chref;
   logic [7:0] ctrl_bits;
   logic [7:0] trig_cfg;
   logic       conv_en;
   logic       start_bit;
   logic       auto_en;
   logic       done_flag;
   logic [2:0] prescale;
   logic [7:0] trig_flags;
   logic [7:0] trig_flags_meta;
   logic [7:0] trig_flags_sync;
   logic       trig_level;
   logic       trig_prev;
   logic       trig_edge;
   logic [7:0] res_low;
   logic [7:0] res_high;
   logic       res_lock;
   logic       first_conv;
   logic [6:0] ps_cnt;
   logic       ps_tick;
   logic       ps_reset;
   logic [4:0] cyc;
   logic [4:0] conv_len;
   adcc_pkg::adcc_state_t state;
   logic       sw_start;
   logic       start_now;
   logic       finish;
   logic [9:0] sar_trial;
   logic [9:0] sar_code;
   logic       sar_full;
   logic       sar_clear;
   logic       wr_ctrl;
   logic       rd_low;
   logic       rd_high;
   logic [15:0] just;
   logic       free_run;

   assign conv_en  = ctrl_bits[adcc_pkg::EN_BIT];
   assign auto_en  = ctrl_bits[adcc_pkg::ATE_BIT];
   assign prescale = ctrl_bits[adcc_pkg::PS_LSB +: adcc_pkg::PS_W];
   assign wr_ctrl  = reg_wr && (reg_addr == adcc_pkg::ADDR_CTRL);
   assign rd_low   = reg_rd && (reg_addr == adcc_pkg::ADDR_LOW);
   assign rd_high  = reg_rd && (reg_addr == adcc_pkg::ADDR_HIGH);
   assign sw_start = wr_ctrl && reg_wdata[adcc_pkg::SC_BIT]
                     && reg_wdata[adcc_pkg::EN_BIT];
   assign free_run = auto_en && (trig_cfg[adcc_pkg::TS_LSB +: adcc_pkg::TS_W]
                     == adcc_pkg::TS_FREE);

   // Software-written configuration registers
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         chref     <= adcc_pkg::ZERO8;
         ctrl_bits <= adcc_pkg::ZERO8;
         trig_cfg  <= adcc_pkg::ZERO8;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            adcc_pkg::ADDR_CHREF: chref    <= reg_wdata;
            adcc_pkg::ADDR_CTRL:  ctrl_bits <= reg_wdata;
            adcc_pkg::ADDR_TRIG:  trig_cfg <= reg_wdata;
            default:              chref    <= chref;
         endcase
      end
   end

   // Trigger flag pins come from elsewhere: two-stage synchroniser
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         trig_flags_meta <= adcc_pkg::ZERO8;
         trig_flags_sync <= adcc_pkg::ZERO8;
      end
      else
      begin
         trig_flags_meta <= trig_flag_set;
         trig_flags_sync <= trig_flags_meta;
      end
   end

   // Sticky trigger flags: set wins over a write-one clear
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         trig_flags <= adcc_pkg::ZERO8;
      else if (reg_wr && reg_addr == adcc_pkg::ADDR_FLAGCLR)
         trig_flags <= (trig_flags & ~reg_wdata) | trig_flags_sync;
      else
         trig_flags <= trig_flags | trig_flags_sync;
   end

   // Selected trigger level; own completion flag for source zero
   always_comb
   begin
      if (free_run)
         trig_level = done_flag;
      else
         trig_level = trig_flags[trig_cfg[adcc_pkg::TS_LSB +: adcc_pkg::TS_W]];
   end

   // Edge detector: a level still high never retriggers
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         trig_prev <= 1'b0;
      else
         trig_prev <= trig_level;
   end
   // Free running restarts on completion; others need an idle-time edge
   assign trig_edge = auto_en && !free_run && trig_level && !trig_prev
                      && state == adcc_pkg::ADCC_IDLE;

   // Prescaler: held clear while disabled, cleared on a trigger edge
   assign ps_reset = !conv_en || trig_edge;
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         ps_cnt <= 7'h00;
      else if (ps_reset)
         ps_cnt <= 7'h00;
      else
         ps_cnt <= ps_cnt + 7'h01;
   end
   // Converter clock tick at ratio two to the power of the field, min two
   always_comb
   begin
      if (prescale == 3'h0)
         ps_tick = ps_cnt[0];
      else
         ps_tick = (ps_cnt & ((7'h01 << prescale) - 7'h01)) ==
                   ((7'h01 << prescale) - 7'h01);
   end

   // Start pending: software write or trigger edge
   assign start_now = start_bit && state == adcc_pkg::ADCC_IDLE && ps_tick;
   assign conv_len  = first_conv ? adcc_pkg::CONV_FIRST
                                 : adcc_pkg::CONV_NORMAL;
   assign finish    = state == adcc_pkg::ADCC_CONV && ps_tick
                      && cyc == conv_len - 5'd1;

   // start_conversion: set by write or trigger, cleared at completion unless free running
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         start_bit <= 1'b0;
      else if (!conv_en && !sw_start)
         start_bit <= 1'b0;
      else if (sw_start || trig_edge)
         start_bit <= 1'b1;
      else if (finish && !free_run)
         start_bit <= 1'b0;
   end

   // Conversion sequencer in converter clock steps
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= adcc_pkg::ADCC_IDLE;
         cyc   <= 5'd0;
      end
      else if (!conv_en)
      begin
         state <= adcc_pkg::ADCC_IDLE;
         cyc   <= 5'd0;
      end
      else
      begin
         case (state)
            adcc_pkg::ADCC_IDLE:
               if (start_now)
               begin
                  state <= adcc_pkg::ADCC_CONV;
                  cyc   <= 5'd0;
               end
            adcc_pkg::ADCC_CONV:
               if (finish)
                  state <= adcc_pkg::ADCC_DONE;
               else if (ps_tick)
                  cyc <= cyc + 5'd1;
            adcc_pkg::ADCC_DONE:
               state <= adcc_pkg::ADCC_IDLE; // restarts via start_bit
            default:
               state <= adcc_pkg::ADCC_IDLE;
         endcase
      end
   end

   // First conversion after enable is the long one
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         first_conv <= 1'b1;
      else if (!conv_en)
         first_conv <= 1'b1;
      else if (finish)
         first_conv <= 1'b0;
   end

   // Ten decisions end one step early so the code is settled at finish
   assign sar_clear = start_now;
   adcc_sar u_sar
   (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .clear     (sar_clear),
      .step      (ps_tick && state == adcc_pkg::ADCC_CONV
                  && cyc >= conv_len - 5'(adcc_pkg::RES_W) - 5'd1
                  && !finish),
      .comp_high (comp_high),
      .trial     (sar_trial),
      .code      (sar_code),
      .full      (sar_full)
   );

   // Justification of the finished code
   assign just = chref[adcc_pkg::LADJ_BIT] ? {sar_code, 6'h00}
                                           : {6'h00, sar_code};

   // Result bytes with low-then-high read lock
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         res_low  <= adcc_pkg::ZERO8;
         res_high <= adcc_pkg::ZERO8;
      end
      else if (finish && !res_lock)
      begin
         res_low  <= just[7:0];
         res_high <= just[15:8];
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         res_lock <= 1'b0;
      else if (rd_high)
         res_lock <= 1'b0;
      else if (rd_low)
         res_lock <= 1'b1;
   end

   // Completion flag: hardware set wins over write-one clear
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         done_flag <= 1'b0;
      else if (finish)
         done_flag <= 1'b1;
      else if (wr_ctrl && reg_wdata[adcc_pkg::CCF_BIT])
         done_flag <= 1'b0;
   end

   // Analog path: while enabled, tracks outside a conversion or in its last step, else held
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mux_select  <= 5'h00;
         gain_select <= adcc_pkg::GAIN_BYP;
         gain_bypass <= 1'b1;
         ref_select  <= adcc_pkg::REF_PIN;
      end
      else if (conv_en && (state != adcc_pkg::ADCC_CONV
               || cyc == conv_len - 5'd1))
      begin
         mux_select  <= chref[adcc_pkg::CH_LSB +: adcc_pkg::CH_W];
         gain_select <= adcc_pkg::gain_of(chref[4:0]);
         gain_bypass <= chref[4:0] < adcc_pkg::CH_DIFF_FIRST;
         ref_select  <= chref[adcc_pkg::REF_LSB +: 2];
      end
   end

   // Front-end drive: trial code, power and sample-hold
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dac_code      <= 10'h000;
         analog_enable <= 1'b0;
         sample_hold   <= 1'b0;
      end
      else
      begin
         dac_code      <= sar_trial;
         analog_enable <= conv_en; // Off draws no power
         sample_hold   <= state == adcc_pkg::ADCC_CONV && !sar_full;
      end
   end

   // Read port: data stand the cycle after the strobe
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= adcc_pkg::ZERO8;
      else if (reg_rd)
      begin
         case (reg_addr)
            adcc_pkg::ADDR_CHREF:   reg_rdata <= chref;
            adcc_pkg::ADDR_CTRL:    reg_rdata <= {conv_en, start_bit, auto_en,
                                     done_flag, ctrl_bits[3:0]};
            adcc_pkg::ADDR_TRIG:    reg_rdata <= trig_cfg;
            adcc_pkg::ADDR_LOW:     reg_rdata <= res_low;
            adcc_pkg::ADDR_HIGH:    reg_rdata <= res_high;
            adcc_pkg::ADDR_FLAGCLR: reg_rdata <= trig_flags;
            default:                reg_rdata <= adcc_pkg::ZERO8;
         endcase
      end
      else
         reg_rdata <= adcc_pkg::ZERO8;
   end

   // Checks
   AST_LOCK_HOLDS: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (res_lock && !rd_high) |=> $stable(res_low))
      else $error("result changed while locked");
   AST_UNLOCK: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rd_high |=> !res_lock)
      else $error("high read did not unlock");
   AST_FLAG_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
      finish |=> done_flag)
      else $error("completion flag not set");
   AST_START_BUSY: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state == adcc_pkg::ADCC_CONV |-> start_bit)
      else $error("start bit low while busy");
   AST_SINGLE_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (finish && !free_run && !sw_start && !trig_edge) |=> !start_bit)
      else $error("start bit not cleared");
   AST_PS_HELD: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !conv_en |=> ps_cnt == 7'h00)
      else $error("prescaler ran while disabled");
   AST_MUX_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state == adcc_pkg::ADCC_CONV && $past(state) == adcc_pkg::ADCC_CONV
       && cyc != conv_len - 5'd1 && $past(cyc) != conv_len - 5'd1)
      |-> $stable(mux_select))
      else $error("channel changed mid conversion");
   AST_BYPASS: assert property (@(posedge sys_clk) disable iff (!rst_n)
      gain_bypass |-> gain_select == adcc_pkg::GAIN_BYP)
      else $error("gain used on single ended");
   AST_LEN: assert property (@(posedge sys_clk) disable iff (!rst_n)
      finish |-> cyc == (first_conv ? 5'd24 : 5'd12))
      else $error("wrong conversion length");
   COV_SINGLE: cover property (@(posedge sys_clk) finish && !auto_en);
   COV_FREE: cover property (@(posedge sys_clk) finish && free_run);
   COV_LOST: cover property (@(posedge sys_clk) finish && res_lock);
endmodule
`default_nettype wire

// ==== adcc_fe_model.sv ====
// Behavioural analog front end: held input and comparator
`timescale 1ns/1ps
`default_nettype none
module adcc_fe_model
(
   input  wire logic       sys_clk,
   input  wire logic [9:0] level,
   input  wire logic [9:0] dac_code,
   input  wire logic       analog_enable,
   input  wire logic       sample_hold,
   output logic            comp_high
);
   logic [9:0] held;
   logic       junk = 1'b0;

   // Track the input until sampling, then hold it for the decisions
   always_ff @(posedge sys_clk)
   begin
      if (!sample_hold)
         held <= level;
      junk <= ~junk;
   end

   // Half-step offset avoids a tie; unpowered output toggles freely
   always_comb
   begin
      if (analog_enable)
         comp_high = {held, 1'b1} > {dac_code, 1'b0};
      else
         comp_high = junk;
   end
endmodule
`default_nettype wire

// ==== adcc_top_tb_top.sv ====
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adcc_top_tb_top;
   logic       sys_clk;
   logic       rst_n;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic [7:0] trig_flag_set;
   logic       comp_high;
   logic [9:0] dac_code;
   logic [4:0] mux_select;
   logic [1:0] gain_select;
   logic       gain_bypass;
   logic [1:0] ref_select;
   logic       analog_enable;
   logic       sample_hold;
   logic [9:0] level;
   logic [9:0] old;
   logic [7:0] d;
   logic [7:0] lo;
   logic       sh_q;
   integer     seed;
   integer     bad_count;
   integer     check_count;
   integer     cyc;
   integer     rises;
   integer     t0;
   integer     i;

   adcc_top adcc_top_inst
   (
      .sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .trig_flag_set, .comp_high, .dac_code, .mux_select,
      .gain_select, .gain_bypass, .ref_select, .analog_enable,
      .sample_hold
   );

   adcc_fe_model adcc_fe_model_inst
   (
      .sys_clk, .level, .dac_code, .analog_enable, .sample_hold,
      .comp_high
   );

   // Free-running 20 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // Cycle count, hang limit and count of sampling phases
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      sh_q <= sample_hold;
      if (sample_hold && !sh_q)
         rises <= rises + 1;
      if (cyc == 20000)
      begin
         bad_count = bad_count + 1;
         test_done;
      end
   end

   // Report counts and the verdict, then stop
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count = check_count + 1;
      if (got !== exp)
      begin
         bad_count = bad_count + 1;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One-cycle write strobe; ends off the edge so outputs are settled
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
      @(negedge sys_clk);
   endtask

   // One-cycle read strobe; data taken in the following cycle only
   task automatic rd(input logic [2:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      @(negedge sys_clk);
      d = reg_rdata;
   endtask

   // One-cycle event on trigger flag 1
   task automatic pulse;
      @(posedge sys_clk);
      trig_flag_set <= 8'h02;
      @(posedge sys_clk);
      trig_flag_set <= 8'h00;
      @(negedge sys_clk);
   endtask

   // Poll the start bit to the end of a run and time it from t0
   task automatic wt(input integer lo_t, input integer hi_t);
      integer n;
      n = 0;
      rd(3'h1);
      chk(d[6], 1'b1);
      while (d[6] === 1'b1 && n < 200)
      begin
         rd(3'h1);
         n = n + 1;
      end
      chk(d[6], 1'b0);
      chk(d[4], 1'b1);
      chk(cyc - t0 >= lo_t && cyc - t0 <= hi_t, 1'b1);
   endtask

   // Expected byte pair for a code under either justification
   function automatic logic [15:0] exp_res(input logic [9:0] v,
                                           input logic       la);
      exp_res = la ? {v, 6'h00} : {6'h00, v};
   endfunction

   // Low byte first for a coherent pair, then compare the justified code
   task automatic res(input logic [9:0] v, input logic la);
      rd(3'h3);
      lo = d;
      rd(3'h4);
      chk({d, lo}, exp_res(v, la));
   endtask

   // Main sequence
   initial
   begin
      seed = 32'h138f;
      bad_count = 0;
      check_count = 0;
      cyc = 0;
      rises = 0;
      rst_n = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      trig_flag_set = 8'h00;
      level = 10'h000;
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      // Reset state, then every index including the unmapped ones
      chk({gain_select, gain_bypass, analog_enable}, 4'he);
      for (i = 0; i < 8; i++)
      begin
         rd(i[2:0]);
         chk(d, 8'h00);
      end
      // Selections wait for the enable
      wr(3'h0, 8'h45);
      chk({ref_select, mux_select}, 7'h00);
      wr(3'h1, 8'h80);
      repeat (3) @(negedge sys_clk);
      chk({ref_select, mux_select, analog_enable}, 8'h4b);
      // Pair gains, bypass for a single-ended pin, all references
      for (i = 0; i < 4; i++)
      begin
         wr(3'h0, {i[1], i[1] | i[0], 1'b0,
                   (i == 0) ? 5'h03 : 5'h07 + i[4:0]});
         repeat (2) @(negedge sys_clk);
         chk({gain_bypass, gain_select},
             (i == 0) ? 3'h7 : {1'b0, i[1:0] - 2'h1});
         chk(ref_select, {i[1], i[1] | i[0]});
      end
      // First run is long, the rest normal; corner levels then random
      wr(3'h0, 8'h00);
      for (i = 0; i < 5; i++)
      begin
         level <= (i == 0) ? 10'h3ff : (i == 1) ? 10'h000
                  : 10'($random(seed));
         t0 = cyc;
         wr(3'h1, 8'hd0);
         wt((i == 0) ? 50 : 26, (i == 0) ? 60 : 36);
         res(level, 1'b0);
      end
      wr(3'h0, 8'h20);
      level <= 10'($random(seed));
      t0 = cyc;
      wr(3'h1, 8'hd0);
      wt(26, 36);
      res(level, 1'b1);
      // Low byte read locks both bytes until the high byte is read
      old = level;
      rd(3'h3);
      lo = d;
      level <= ~old;
      t0 = cyc;
      wr(3'h1, 8'hd0);
      wt(26, 36);
      rd(3'h4);
      chk({d, lo}, {old, 6'h00});
      t0 = cyc;
      wr(3'h1, 8'hd0);
      wt(26, 36);
      res(level, 1'b1);
      // A channel change during a run waits for its end
      wr(3'h0, 8'h02);
      t0 = cyc;
      wr(3'h1, 8'hd0);
      repeat (4) @(negedge sys_clk);
      wr(3'h0, 8'h04);
      chk(mux_select, 5'h02);
      wt(26, 36);
      chk(mux_select, 5'h04);
      // Trigger flag 1 as source: edges start runs, levels do not
      wr(3'h2, 8'h20);
      wr(3'h1, 8'hb0);
      t0 = cyc;
      pulse;
      repeat (6) @(negedge sys_clk);
      wr(3'h5, 8'h02);
      pulse;
      wt(26, 44);
      repeat (40) @(negedge sys_clk);
      rd(3'h1);
      chk(d[6], 1'b0);
      rd(3'h5);
      chk(d[1], 1'b1);
      wr(3'h5, 8'h02);
      t0 = cyc;
      pulse;
      repeat (4) @(negedge sys_clk);
      wt(26, 44);
      // Own flag as source: software starts, then it runs on its own
      wr(3'h2, 8'h00);
      wr(3'h1, 8'he0);
      i = rises;
      repeat (120) @(negedge sys_clk);
      rd(3'h1);
      chk(d[6], 1'b1);
      chk(rises - i >= 3, 1'b1);
      wr(3'h1, 8'h00);
      repeat (4) @(negedge sys_clk);
      chk(analog_enable, 1'b0);
      test_done;
   end
endmodule
`default_nettype wire
